// *** rtl/pbe_defs.svh ***
// register offsets, field positions, reset values and timing counts of the pci boot/eeprom controller
`ifndef PBE_DEFS_SVH
`define PBE_DEFS_SVH

// register byte offsets
`define PBE_OFS_HOST_CTRL 8'h00
`define PBE_OFS_EV_SRC 8'h04
`define PBE_OFS_EV_EN 8'h08
`define PBE_OFS_RST_SRC 8'h0c
`define PBE_OFS_HOST_STAT 8'h10
`define PBE_OFS_ROM_CTRL 8'h14
`define PBE_OFS_CFG_BASE 8'h40

// host_control_reg bits
`define PBE_HC_WARM_RESET 0
`define PBE_HC_CORE_NOTIFY 1
`define PBE_HC_STALLED 2
// reset_source_reg bits
`define PBE_RS_IRQ_REQUEST 0
`define PBE_RS_IRQ_CLEAR 1
`define PBE_RS_CONFIG_DONE 2
`define PBE_RS_IRQ_ACTIVE 3
// host_status_reg bits
`define PBE_HS_IRQ_MASK 0
`define PBE_HS_CONFIG_ERROR 1
`define PBE_HS_ROM_READ 2
`define PBE_HS_MASK_RESET 1'b0
// rom_control_reg fields
`define PBE_RC_AUTOINIT 0
`define PBE_RC_SIZE_LO 1
`define PBE_RC_READY 4

// event_source_reg / event_enable_reg bit positions
`define PBE_EV_PM 0
`define PBE_EV_TARGET_ABORT 1
`define PBE_EV_MASTER_ABORT 2
`define PBE_EV_HOST_SOFT 3
`define PBE_EV_POWER_RISE 4
`define PBE_EV_POWER_FALL 5
`define PBE_EV_MASTER_DONE 6
`define PBE_EV_CONFIG_DONE 7
`define PBE_EV_CONFIG_ERROR 8
`define PBE_EV_ROM_READY 9
`define PBE_EV_BUS_RESET 10
`define PBE_EV_W 11

// rom size select codes
`define PBE_SZ_NONE 3'h0
`define PBE_SZ_1K 3'h1
`define PBE_SZ_2K 3'h2
`define PBE_SZ_4K 3'h3
`define PBE_SZ_16K 3'h4
// word address widths per size
`define PBE_AW_1K 4'h6
`define PBE_AW_2K 4'h7
`define PBE_AW_4K 4'h8
`define PBE_AW_16K 4'ha

// serial read frame: start bit then opcode 10
`define PBE_READ_HEAD 16'h0006
`define PBE_DATA_BITS 5'h10
`define PBE_IMAGE_WORDS 14
`define PBE_CSUM_WORD 4'hd
`define PBE_CSUM_SEED 16'haaaa
`define PBE_PMC_WORD 4'hc

// serial clock divider
`define PBE_ROM_DIV 2048

`endif

// *** rtl/pbe_pkg.sv ***
// types of the pci boot/eeprom controller
package pbe_pkg;

   typedef enum logic [2:0] {
      L_IDLE,
      L_WORD,
      L_GAP,
      L_CHECK,
      L_DONE
   } pbe_load_state_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } pbe_bus_req_t;

   typedef struct packed {
      logic autoinit_select;
      logic [2:0] rom_size_select;
      logic pci_mode;
      logic pci_boot;
   } pbe_straps_t;

   typedef struct packed {
      logic pm;
      logic target_abort;
      logic master_abort;
      logic power_rise;
      logic power_fall;
      logic master_done;
   } pbe_events_t;

   typedef struct packed {
      logic [15:0] vendor_id;
      logic [15:0] device_id;
      logic [15:0] class_lo_rev;
      logic [15:0] class_hi;
      logic [15:0] sub_vendor_id;
      logic [15:0] sub_id;
      logic [15:0] max_lat_min_gnt;
      logic [15:0] pc_d1_d0;
      logic [15:0] pc_d3_d2;
      logic [15:0] pd_d1_d0;
      logic [15:0] pd_d3_d2;
      logic [15:0] data_scale;
      logic [7:0] pm_capability_bits;
   } pbe_cfg_t;

endpackage

// *** rtl/pbe_ctl.sv ***
// pci port reset, event reporting, boot release and eeprom autoinit loader
//
// Implementation choices: strobed register access and the address map.
`timescale 1ns/1ps
`include "pbe_defs.svh"

module pbe_ctl #(
   parameter int ROM_DIV = `PBE_ROM_DIV,
   parameter logic [15:0] DEF_VENDOR = 16'h1a2b, // arbitrary value
   parameter logic [15:0] DEF_DEVICE = 16'h3c4d  // arbitrary value
) (
   input wire logic clock,
   input wire logic rstn,
   input wire logic pci_bus_reset_pin_n,
   input wire pbe_pkg::pbe_straps_t straps,
   input wire pbe_pkg::pbe_bus_req_t bus_req,
   output logic [31:0] rdata,
   input wire pbe_pkg::pbe_events_t events_in,
   input wire logic aux_dma_halted,
   input wire logic pm_wake,
   input wire logic serial_rom_rx,
   output logic serial_rom_clock,
   output logic serial_rom_select,
   output logic serial_rom_tx,
   output logic core_notify_irq,
   output logic aux_dma_halt_irq,
   output logic pm_wake_irq,
   output logic host_irq_pin_out,
   output logic host_irq_pin_oe,
   output logic warm_reset,
   output logic wake_deep_sleep,
   output logic fifo_reset,
   output logic pci_disconnect,
   output logic master_inhibit,
   output logic pci_read_retry,
   output logic cpu_stall,
   output pbe_pkg::pbe_cfg_t cfg_image
);

   localparam int DW = $clog2(ROM_DIV);
   localparam logic [DW-1:0] HALF_M1 = DW'(ROM_DIV / 2 - 1);
   localparam int SW = 8;

   // ************************************************************
   // reset and pin synchronisers
   // ************************************************************
   logic rst_meta;
   logic rst_n;
   logic [SW-1:0] pin_raw;
   logic [SW-1:0] pin_meta;
   logic [SW-1:0] pin_sync;
   logic pci_bus_reset_pin;
   logic rom_rx;
   pbe_pkg::pbe_straps_t straps_sync;

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   // no reset here: the bus reset pin must not follow the core reset
   assign pin_raw = {pci_bus_reset_pin_n, straps, serial_rom_rx};

   always_ff @(posedge clock) begin
      pin_meta <= pin_raw;
      pin_sync <= pin_meta;
   end

   assign pci_bus_reset_pin = ~pin_sync[SW-1];
   assign straps_sync = pin_sync[SW-2:1];
   assign rom_rx = pin_sync[0];

   // ************************************************************
   // reset outputs and bus behaviour during reset
   // ************************************************************
   assign fifo_reset = ~rst_n | pci_bus_reset_pin;
   assign pci_disconnect = ~rst_n;
   assign master_inhibit = ~rst_n;

   // ************************************************************
   // boot straps, captured only by the device reset
   // ************************************************************
   logic autoinit_sel;
   logic [2:0] size_sel;
   logic pci_mode;
   logic pci_boot;

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         autoinit_sel <= straps_sync.autoinit_select;
         size_sel <= straps_sync.rom_size_select;
         pci_mode <= straps_sync.pci_mode;
         pci_boot <= straps_sync.pci_boot;
      end
   end

   // ************************************************************
   // register port decode
   // ************************************************************
   logic wr_host_ctrl;
   logic wr_ev_src;
   logic wr_ev_en;
   logic wr_rst_src;
   logic wr_host_stat;

   assign wr_host_ctrl = bus_req.wr && bus_req.addr == `PBE_OFS_HOST_CTRL;
   assign wr_ev_src = bus_req.wr && bus_req.addr == `PBE_OFS_EV_SRC;
   assign wr_ev_en = bus_req.wr && bus_req.addr == `PBE_OFS_EV_EN;
   assign wr_rst_src = bus_req.wr && bus_req.addr == `PBE_OFS_RST_SRC;
   assign wr_host_stat = bus_req.wr && bus_req.addr == `PBE_OFS_HOST_STAT;

   // ************************************************************
   // host control: warm reset and core notify
   // ************************************************************
   logic notify_wr;
   logic released;

   assign notify_wr = wr_host_ctrl && bus_req.wdata[`PBE_HC_CORE_NOTIFY];

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         warm_reset <= 1'b0;
         released <= 1'b0;
      end else begin
         warm_reset <= wr_host_ctrl && bus_req.wdata[`PBE_HC_WARM_RESET];
         released <= released | notify_wr;
      end
   end

   // warm reset does not touch the strap capture above
   assign wake_deep_sleep = warm_reset;
   assign cpu_stall = pci_boot & ~released;

   // ************************************************************
   // eeprom autoinit loader
   // ************************************************************
   pbe_pkg::pbe_load_state_t lstate;
   logic [DW-1:0] div_cnt;
   logic sclk;
   logic [4:0] bit_k;
   logic [3:0] word_idx;
   logic [15:0] shreg;
   logic [15:0] csum;
   logic csum_ok;
   logic cfg_done;
   logic cfg_err;
   logic rom_read;
   logic done_pulse;
   logic err_pulse;
   logic [3:0] aw;
   logic [4:0] nout;
   logic [15:0] cmd_word;
   logic [4:0] tx_idx;
   logic [15:0] rx_word;
   logic busy;
   logic tick;
   logic fall;
   logic size_ok;
   logic autoinit_en;
   logic word_end;
   logic word_we;
   logic load_defaults;

   assign size_ok = size_sel == `PBE_SZ_1K || size_sel == `PBE_SZ_2K || size_sel == `PBE_SZ_4K ||
                    size_sel == `PBE_SZ_16K;
   assign autoinit_en = autoinit_sel && size_ok && pci_mode;
   assign aw = (size_sel == `PBE_SZ_1K) ? `PBE_AW_1K :
               (size_sel == `PBE_SZ_2K) ? `PBE_AW_2K :
               (size_sel == `PBE_SZ_4K) ? `PBE_AW_4K : `PBE_AW_16K;
   assign nout = 5'(aw) + 5'd3;
   // word address only: part organised as 16-bit words
   assign cmd_word = (`PBE_READ_HEAD << aw) | {12'h000, word_idx};
   assign tx_idx = 5'(nout - 5'd2 - bit_k);
   assign rx_word = {shreg[14:0], rom_rx};

   assign busy = lstate == pbe_pkg::L_WORD || lstate == pbe_pkg::L_GAP;
   assign tick = busy && div_cnt == HALF_M1;
   assign fall = tick && sclk;
   assign word_end = lstate == pbe_pkg::L_WORD && fall && bit_k == 5'(nout + `PBE_DATA_BITS - 5'd1);
   assign word_we = word_end && word_idx < `PBE_CSUM_WORD;
   assign load_defaults = (lstate == pbe_pkg::L_IDLE && rst_n && !autoinit_en) ||
                          (lstate == pbe_pkg::L_CHECK && !csum_ok);

   always_ff @(posedge clock) begin
      if (pci_bus_reset_pin) begin
         lstate <= pbe_pkg::L_IDLE;
         div_cnt <= '0;
         sclk <= 1'b0;
         serial_rom_select <= 1'b0;
         serial_rom_tx <= 1'b0;
         bit_k <= 5'h00;
         word_idx <= 4'h0;
         shreg <= 16'h0000;
         csum <= `PBE_CSUM_SEED;
         csum_ok <= 1'b0;
         cfg_done <= 1'b0;
         cfg_err <= 1'b0;
         rom_read <= 1'b0;
         done_pulse <= 1'b0;
         err_pulse <= 1'b0;
      end else begin
         done_pulse <= 1'b0;
         err_pulse <= 1'b0;
         div_cnt <= (busy && div_cnt != HALF_M1) ? div_cnt + 1'b1 : '0;
         case (lstate)
            pbe_pkg::L_IDLE: begin
               if (rst_n && autoinit_en) begin
                  lstate <= pbe_pkg::L_WORD;
                  serial_rom_select <= 1'b1;
                  serial_rom_tx <= 1'b1;
                  rom_read <= 1'b1;
               end else if (rst_n) begin
                  lstate <= pbe_pkg::L_DONE;
                  cfg_done <= 1'b1;
                  done_pulse <= 1'b1;
               end
            end
            pbe_pkg::L_WORD: begin
               if (tick) begin
                  sclk <= ~sclk;
               end
               if (fall) begin
                  bit_k <= bit_k + 5'd1;
                  serial_rom_tx <= (bit_k + 5'd1 < nout) ? cmd_word[tx_idx[3:0]] : 1'b0;
                  if (bit_k >= nout) begin
                     shreg <= rx_word;
                  end
               end
               if (word_end) begin
                  serial_rom_select <= 1'b0;
                  lstate <= pbe_pkg::L_GAP;
                  if (word_idx < `PBE_CSUM_WORD) begin
                     csum <= csum ^ rx_word;
                  end else begin
                     csum_ok <= csum == rx_word;
                  end
               end
            end
            pbe_pkg::L_GAP: begin
               if (tick) begin
                  bit_k <= 5'h00;
                  if (word_idx == `PBE_CSUM_WORD) begin
                     lstate <= pbe_pkg::L_CHECK;
                  end else begin
                     word_idx <= word_idx + 4'h1;
                     lstate <= pbe_pkg::L_WORD;
                     serial_rom_select <= 1'b1;
                     serial_rom_tx <= 1'b1;
                  end
               end
            end
            pbe_pkg::L_CHECK: begin
               lstate <= pbe_pkg::L_DONE;
               cfg_done <= 1'b1;
               done_pulse <= 1'b1;
               cfg_err <= ~csum_ok;
               err_pulse <= ~csum_ok;
            end
            default: begin
               lstate <= pbe_pkg::L_DONE;
            end
         endcase
      end
   end

   assign serial_rom_clock = sclk;
   assign pci_read_retry = ~cfg_done;

   // ************************************************************
   // configuration words, one per image entry before the checksum word
   // ************************************************************
   logic [15:0] cfg_word [0:`PBE_CSUM_WORD-1];

   genvar gi;
   generate
      for (gi = 0; gi < `PBE_CSUM_WORD; gi++) begin : g_cfg
         localparam logic [15:0] DEF = (gi == 0) ? DEF_VENDOR : (gi == 1) ? DEF_DEVICE : 16'h0000;
         localparam logic [3:0] IDX = 4'(gi);
         logic [15:0] load_val;
         // upper byte of the capability word is forced to zero
         assign load_val = (IDX == `PBE_PMC_WORD) ? {8'h00, rx_word[7:0]} : rx_word;
         always_ff @(posedge clock) begin
            if (pci_bus_reset_pin || load_defaults) begin
               cfg_word[gi] <= DEF;
            end else if (word_we && word_idx == IDX) begin
               cfg_word[gi] <= load_val;
            end
         end
      end
   endgenerate

   assign cfg_image.vendor_id = cfg_word[0];
   assign cfg_image.device_id = cfg_word[1];
   assign cfg_image.class_lo_rev = cfg_word[2];
   assign cfg_image.class_hi = cfg_word[3];
   assign cfg_image.sub_vendor_id = cfg_word[4];
   assign cfg_image.sub_id = cfg_word[5];
   assign cfg_image.max_lat_min_gnt = cfg_word[6];
   assign cfg_image.pc_d1_d0 = cfg_word[7];
   assign cfg_image.pc_d3_d2 = cfg_word[8];
   assign cfg_image.pd_d1_d0 = cfg_word[9];
   assign cfg_image.pd_d3_d2 = cfg_word[10];
   assign cfg_image.data_scale = cfg_word[11];
   assign cfg_image.pm_capability_bits = cfg_word[12][7:0];

   // ************************************************************
   // event source / enable and core interrupts
   // ************************************************************
   logic [`PBE_EV_W-1:0] event_src;
   logic [`PBE_EV_W-1:0] event_en;
   logic [`PBE_EV_W-1:0] ev_set;
   logic [`PBE_EV_W-1:0] ev_clr;
   logic pci_bus_reset_pin_q;
   logic dma_q;
   logic wake_q;

   assign ev_set[`PBE_EV_PM] = events_in.pm;
   assign ev_set[`PBE_EV_TARGET_ABORT] = events_in.target_abort;
   assign ev_set[`PBE_EV_MASTER_ABORT] = events_in.master_abort;
   assign ev_set[`PBE_EV_HOST_SOFT] = notify_wr;
   assign ev_set[`PBE_EV_POWER_RISE] = events_in.power_rise;
   assign ev_set[`PBE_EV_POWER_FALL] = events_in.power_fall;
   assign ev_set[`PBE_EV_MASTER_DONE] = events_in.master_done;
   assign ev_set[`PBE_EV_CONFIG_DONE] = done_pulse;
   assign ev_set[`PBE_EV_CONFIG_ERROR] = err_pulse;
   assign ev_set[`PBE_EV_ROM_READY] = done_pulse;
   assign ev_set[`PBE_EV_BUS_RESET] = pci_bus_reset_pin & ~pci_bus_reset_pin_q;
   assign ev_clr = wr_ev_src ? bus_req.wdata[`PBE_EV_W-1:0] : '0;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         event_src <= '0;
         event_en <= '0;
         pci_bus_reset_pin_q <= 1'b0;
         dma_q <= 1'b0;
         wake_q <= 1'b0;
         aux_dma_halt_irq <= 1'b0;
         pm_wake_irq <= 1'b0;
      end else begin
         // a set in the clearing cycle wins
         event_src <= (event_src & ~ev_clr) | ev_set;
         event_en <= wr_ev_en ? bus_req.wdata[`PBE_EV_W-1:0] : event_en;
         pci_bus_reset_pin_q <= pci_bus_reset_pin;
         dma_q <= aux_dma_halted;
         wake_q <= pm_wake;
         aux_dma_halt_irq <= aux_dma_halted & ~dma_q;
         pm_wake_irq <= pm_wake & ~wake_q;
      end
   end

   // level: stays up while any enabled source is pending
   assign core_notify_irq = |(event_src & event_en);

   // ************************************************************
   // host interrupt pin
   // ************************************************************
   logic irq_active;
   logic irq_mask;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         irq_active <= 1'b0;
         irq_mask <= `PBE_HS_MASK_RESET;
      end else begin
         irq_active <= (irq_active & ~(wr_rst_src & bus_req.wdata[`PBE_RS_IRQ_CLEAR])) |
                       (wr_rst_src & bus_req.wdata[`PBE_RS_IRQ_REQUEST]);
         irq_mask <= wr_host_stat ? bus_req.wdata[`PBE_HS_IRQ_MASK] : irq_mask;
      end
   end

   // open drain, active low: drive low only while enabled
   assign host_irq_pin_out = 1'b0;
   assign host_irq_pin_oe = irq_active & ~irq_mask;

   // ************************************************************
   // read path
   // ************************************************************
   logic [31:0] rd_mux;
   logic [31:0] host_ctrl_val;
   logic [31:0] rst_src_val;
   logic [31:0] host_stat_val;
   logic [31:0] rom_ctrl_val;
   logic cfg_hit;
   logic [3:0] cfg_sel;

   assign host_ctrl_val = {29'h0, cpu_stall, 2'b00};
   assign rst_src_val = {28'h0, irq_active, cfg_done, 2'b00};
   assign host_stat_val = {29'h0, rom_read, cfg_err, irq_mask};
   assign rom_ctrl_val = {27'h0, cfg_done, size_sel, autoinit_sel};
   assign cfg_sel = bus_req.addr[5:2];
   assign cfg_hit = bus_req.addr[7:6] == 2'b01 && bus_req.addr[1:0] == 2'b00 && cfg_sel < `PBE_CSUM_WORD;
   assign rd_mux = (bus_req.addr == `PBE_OFS_HOST_CTRL) ? host_ctrl_val :
                   (bus_req.addr == `PBE_OFS_EV_SRC) ? {21'h0, event_src} :
                   (bus_req.addr == `PBE_OFS_EV_EN) ? {21'h0, event_en} :
                   (bus_req.addr == `PBE_OFS_RST_SRC) ? rst_src_val :
                   (bus_req.addr == `PBE_OFS_HOST_STAT) ? host_stat_val :
                   (bus_req.addr == `PBE_OFS_ROM_CTRL) ? rom_ctrl_val :
                   cfg_hit ? {16'h0, cfg_word[cfg_sel]} : 32'h0000_0000;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rdata <= 32'h0000_0000;
      end else begin
         rdata <= bus_req.rd ? rd_mux : 32'h0000_0000;
      end
   end

endmodule

// *** verification/pbe_ctl_asserts.sv ***
// concurrent checks on the ports of the pci boot/eeprom controller
`timescale 1ns/1ps
`include "pbe_defs.svh"
module pbe_ctl_asserts #(
   parameter int ROM_DIV = `PBE_ROM_DIV
) (
   input wire logic clock,
   input wire logic rstn,
   input wire logic pci_bus_reset_pin_n,
   input wire pbe_pkg::pbe_bus_req_t bus_req,
   input wire logic aux_dma_halted,
   input wire logic pm_wake,
   input wire logic serial_rom_clock,
   input wire logic serial_rom_select,
   input wire logic serial_rom_tx,
   input wire logic aux_dma_halt_irq,
   input wire logic pm_wake_irq,
   input wire logic host_irq_pin_out,
   input wire logic host_irq_pin_oe,
   input wire logic warm_reset,
   input wire logic wake_deep_sleep,
   input wire logic fifo_reset,
   input wire logic pci_disconnect,
   input wire logic master_inhibit,
   input wire logic pci_read_retry
);
   // ***************
   // helpers
   // ***************
   default clocking @(posedge clock); endclocking
   wire logic rs_wr = bus_req.wr && bus_req.addr == `PBE_OFS_RST_SRC;
   wire logic hc_wr = bus_req.wr && bus_req.addr == `PBE_OFS_HOST_CTRL;
   logic prev_clk;
   int half;
   always_ff @(posedge clock) begin
      prev_clk <= serial_rom_clock;
      half <= (!serial_rom_select || serial_rom_clock != prev_clk) ? 0 : half + 1;
   end
   property p_rst_hold; !rstn |-> fifo_reset && pci_disconnect && master_inhibit; endproperty
   a_rst_hold: assert property (p_rst_hold) else $error("port active in reset");
   property p_bus_rst; !pci_bus_reset_pin_n [*4] |-> fifo_reset && pci_read_retry; endproperty
   a_bus_rst: assert property (p_bus_rst) else $error("bus reset ignored");
   property p_irq_cause; disable iff (!rstn) $rose(host_irq_pin_oe) |-> $past(rs_wr && bus_req.wdata[0]); endproperty
   a_irq_cause: assert property (p_irq_cause) else $error("host irq without request");
   property p_irq_clr; disable iff (!rstn) rs_wr && bus_req.wdata[1:0] == 2'h2 |=> !host_irq_pin_oe; endproperty
   a_irq_clr: assert property (p_irq_clr) else $error("host irq not cleared");
   property p_pin_low; host_irq_pin_out == 1'b0; endproperty
   a_pin_low: assert property (p_pin_low) else $error("host irq pin driven high");
   property p_warm; disable iff (!rstn) hc_wr && bus_req.wdata[0] |=> warm_reset && wake_deep_sleep ##1 !warm_reset;
   endproperty
   a_warm: assert property (p_warm) else $error("warm reset pulse wrong");
   property p_dma; disable iff (!rstn) $rose(aux_dma_halted) |-> ##[1:4] aux_dma_halt_irq ##1 !aux_dma_halt_irq;
   endproperty
   a_dma: assert property (p_dma) else $error("no halt interrupt");
   property p_wake; disable iff (!rstn) $rose(pm_wake) |-> ##[1:4] pm_wake_irq; endproperty
   a_wake: assert property (p_wake) else $error("no wake interrupt");
   property p_idle; disable iff (!pci_bus_reset_pin_n) !serial_rom_select |-> !serial_rom_clock; endproperty
   a_idle: assert property (p_idle) else $error("serial clock outside access");
   property p_div; disable iff (!pci_bus_reset_pin_n) $fell(serial_rom_clock) |-> half == ROM_DIV / 2 - 1; endproperty
   a_div: assert property (p_div) else $error("serial clock half period wrong");
   property p_start; disable iff (!pci_bus_reset_pin_n) $rose(serial_rom_select) |-> serial_rom_tx; endproperty
   a_start: assert property (p_start) else $error("no start bit");
   c_host: cover property ($rose(host_irq_pin_oe));
   c_frame: cover property ($fell(serial_rom_select));
   c_warm: cover property (warm_reset);
endmodule
bind pbe_ctl pbe_ctl_asserts #(.ROM_DIV(ROM_DIV)) u_chk (.clock, .rstn, .pci_bus_reset_pin_n, .bus_req,
   .aux_dma_halted, .pm_wake, .serial_rom_clock, .serial_rom_select, .serial_rom_tx, .aux_dma_halt_irq,
   .pm_wake_irq, .host_irq_pin_out, .host_irq_pin_oe, .warm_reset, .wake_deep_sleep, .fifo_reset,
   .pci_disconnect, .master_inhibit, .pci_read_retry);

// *** verification/pbe_rom_model.sv ***
// serial configuration memory answering read frames
`timescale 1ns/1ps
module pbe_rom_model #(
   parameter int AW = 8
) (
   input wire logic serial_rom_clock,
   input wire logic serial_rom_select,
   input wire logic serial_rom_tx,
   input wire logic [15:0] image [14],
   output logic serial_rom_rx
);
   // ***************
   // frame decode
   // ***************
   logic [15:0] sh;
   logic [15:0] q;
   int n;
   initial serial_rom_rx = 1'b0;
   always @(posedge serial_rom_select) begin
      n = 0;
      sh = '0;
   end
   // data pin pulled down once released
   always @(negedge serial_rom_select) serial_rom_rx = 1'b0;
   always @(posedge serial_rom_clock) begin
      if (serial_rom_select) begin
         n++;
         if (n <= AW + 3) sh = {sh[14:0], serial_rom_tx};
         if (n == AW + 3) begin
            q = (sh[AW+2:AW] == 3'b110 && sh[AW-1:0] < 14) ? image[sh[AW-1:0]] : 16'h0;
            serial_rom_rx = 1'b0;
         end
         if (n > AW + 3) begin
            serial_rom_rx = q[15];
            q = {q[14:0], 1'b0};
         end
      end
   end
endmodule

// *** verification/tb_pbe_ctl.sv ***
// self-checking bench of the pci boot/eeprom controller
`timescale 1ns/1ps
`include "pbe_defs.svh"
module tb_pbe_ctl;
   localparam logic [15:0] VEN = 16'h5e6f; // arbitrary value
   localparam logic [15:0] DEV = 16'h7a8b; // arbitrary value
   logic clock = 0, rstn, pci_bus_reset_pin_n = 0, aux_dma_halted = 0, pm_wake = 0;
   pbe_pkg::pbe_straps_t straps = '{1'b1, 3'h3, 1'b1, 1'b1};
   pbe_pkg::pbe_bus_req_t bus_req = '0;
   pbe_pkg::pbe_events_t events_in = '0;
   logic [31:0] rdata;
   logic serial_rom_rx, serial_rom_clock, serial_rom_select, serial_rom_tx, core_notify_irq, aux_dma_halt_irq;
   logic pm_wake_irq, host_irq_pin_out, host_irq_pin_oe, warm_reset, wake_deep_sleep, fifo_reset;
   logic pci_disconnect, master_inhibit, pci_read_retry, cpu_stall;
   pbe_pkg::pbe_cfg_t cfg_image;
   logic [15:0] image [14];
   int error_cnt = 0, check_count = 0, sel_cnt = 0, n = 0;
   int pos [6] = '{0, 1, 2, 4, 5, 6};
   always #10 clock = ~clock;
   always @(posedge serial_rom_select) sel_cnt++;
   pbe_ctl #(.ROM_DIV(8), .DEF_VENDOR(VEN), .DEF_DEVICE(DEV)) dut (.clock, .rstn, .pci_bus_reset_pin_n, .straps,
      .bus_req, .rdata, .events_in, .aux_dma_halted, .pm_wake, .serial_rom_rx, .serial_rom_clock,
      .serial_rom_select, .serial_rom_tx, .core_notify_irq, .aux_dma_halt_irq, .pm_wake_irq, .host_irq_pin_out,
      .host_irq_pin_oe, .warm_reset, .wake_deep_sleep, .fifo_reset, .pci_disconnect, .master_inhibit,
      .pci_read_retry, .cpu_stall, .cfg_image);
   pbe_rom_model #(.AW(8)) rom (.serial_rom_clock, .serial_rom_select, .serial_rom_tx, .image, .serial_rom_rx);
   // ***************
   // tasks
   // ***************
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock) bus_req <= '{a, d, 1'b1, 1'b0};
      @(posedge clock) bus_req <= '0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m = 32'hffffffff);
      @(posedge clock) bus_req <= '{a, 32'h0, 1'b0, 1'b1};
      @(posedge clock) bus_req <= '0;
      #1 chk(rdata & m, exp);
   endtask
   task automatic pulse(input logic dv, input logic bs);
      @(posedge clock) rstn <= !dv;
      pci_bus_reset_pin_n <= !bs;
      repeat (5) @(posedge clock);
      {rstn, pci_bus_reset_pin_n} <= 2'b11;
      repeat (3) @(posedge clock);
   endtask
   task automatic waitdone;
      for (int i = 0; i < 20000 && pci_read_retry !== 1'b0; i++) @(posedge clock);
      #1 chk(pci_read_retry, 1'b0);
   endtask
   task automatic cfgchk(input logic dflt);
      logic [15:0] e;
      for (int i = 0; i < 13; i++) begin
         e = !dflt ? image[i] : i == 0 ? VEN : i == 1 ? DEV : 16'h0;
         rd(8'h40 + 8'(4 * i), {16'h0, e});
      end
   endtask
   task automatic conclude;
      $display("errors %0d checks %0d", error_cnt, check_count);
      if (error_cnt == 0 && check_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      #1000000;
      error_cnt++;
      conclude;
   end
   initial begin
      rstn <= 1'b0;
      for (int i = 0; i < 13; i++) image[i] = 16'h1357 + 16'h0f1f * 16'(i);
      image[12] = 16'h00a5;
      image[13] = 16'haaaa;
      for (int i = 0; i < 13; i++) image[13] ^= image[i];
      repeat (4) @(posedge clock);
      #1 chk({fifo_reset, pci_disconnect, master_inhibit, host_irq_pin_oe}, 4'he);
      @(posedge clock) rstn <= 1'b1;
      repeat (4) @(posedge clock);
      #1 chk({fifo_reset, pci_disconnect}, 2'b10);
      @(posedge clock) pci_bus_reset_pin_n <= 1'b1;
      waitdone;
      chk(sel_cnt, 14);
      rd(`PBE_OFS_ROM_CTRL, 32'h17);
      rd(`PBE_OFS_HOST_STAT, 32'h4);
      rd(`PBE_OFS_HOST_CTRL, 32'h4);
      cfgchk(1'b0);
      chk(cfg_image[199:168], {image[0], image[1]});
      pulse(1'b1, 1'b0);
      cfgchk(1'b0);
      $display("load test ended");
      wr(`PBE_OFS_EV_SRC, 32'h7ff);
      for (int i = 0; i < 6; i++) begin
         @(posedge clock) events_in <= 6'h20 >> i;
         @(posedge clock) events_in <= '0;
         #1 chk(core_notify_irq, 1'b0);
         rd(`PBE_OFS_EV_SRC, 32'h1 << pos[i]);
         wr(`PBE_OFS_EV_EN, 32'h1 << pos[i]);
         #1 chk(core_notify_irq, 1'b1);
         wr(`PBE_OFS_EV_SRC, 32'h1 << pos[i]);
         #1 chk(core_notify_irq, 1'b0);
      end
      @(posedge clock) events_in <= 6'h01;
      bus_req <= '{`PBE_OFS_EV_SRC, 32'h40, 1'b1, 1'b0};
      @(posedge clock) events_in <= '0;
      bus_req <= '0;
      #1 chk(core_notify_irq, 1'b1);
      wr(`PBE_OFS_EV_SRC, 32'h7ff);
      wr(`PBE_OFS_EV_EN, 32'h8);
      wr(`PBE_OFS_HOST_CTRL, 32'h2);
      #1 chk({core_notify_irq, cpu_stall}, 2'b10);
      $display("event test ended");
      @(posedge clock) straps.rom_size_select <= 3'h0;
      wr(`PBE_OFS_HOST_CTRL, 32'h1);
      #1 chk({warm_reset, wake_deep_sleep, cpu_stall}, 3'b110);
      rd(`PBE_OFS_ROM_CTRL, 32'h17);
      wr(`PBE_OFS_RST_SRC, 32'h1);
      #1 chk({host_irq_pin_oe, host_irq_pin_out}, 2'b10);
      rd(`PBE_OFS_RST_SRC, 32'hc);
      wr(`PBE_OFS_RST_SRC, 32'h2);
      #1 chk(host_irq_pin_oe, 1'b0);
      wr(`PBE_OFS_HOST_STAT, 32'h1);
      wr(`PBE_OFS_RST_SRC, 32'h1);
      #1 chk(host_irq_pin_oe, 1'b0);
      wr(`PBE_OFS_RST_SRC, 32'h2);
      @(posedge clock) {aux_dma_halted, pm_wake} <= 2'b11;
      repeat (6) begin
         @(posedge clock);
         #1 n += aux_dma_halt_irq + pm_wake_irq;
      end
      chk(n, 2);
      $display("host test ended");
      image[13] ^= 16'h0001;
      pulse(1'b0, 1'b1);
      waitdone;
      cfgchk(1'b1);
      rd(`PBE_OFS_HOST_STAT, 32'h6, 32'h6);
      rd(`PBE_OFS_EV_SRC, 32'h580, 32'h580);
      sel_cnt = 0;
      pulse(1'b1, 1'b1);
      waitdone;
      chk(sel_cnt, 0);
      cfgchk(1'b1);
      rd(`PBE_OFS_ROM_CTRL, 32'h11);
      rd(`PBE_OFS_HOST_STAT, 32'h0, 32'h6);
      $display("default test ended");
      conclude;
   end
endmodule
